// >>> design/bat_seq.sv
// Trigger sequencer for two multi-bunch capture engines and one single-bunch engine.
// Assumes sample_valid marks one bunch sample on pclk; memories sit outside.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Hardware or software trigger starts sequence
// R2: Grow/damp inverts coefficient select at trigger
// R3: Hold-off countdown, skipped when zero
// R4: Virtual trigger at hold-off end
// R5: Inversion kept for growth time
// R6: Select restored when growth time ends
// R7: Capture post-trigger time then stop
// R8: Both engines: pre/post, grow/damp, sources
// R9: Depths 12M and 276k samples
// R10: Single bunch 96k samples post-trigger
// R11: Excitation parameters latched at start
// R12: Three per-bunch enable mask vectors
// R13: Mask bit one enables, zero disables
// R14: Bunches numbered 1 to 470
// R15: Feedback on/off gates filter output
// R16: Sample memory never cleared
// R17: Monitoring: no grow/damp, zero hold-off
// R18: Status summary ok, warning, error
module bat_seq (
   // APB slave
   input  wire  logic        pclk,
   input  wire  logic        presetn,
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic              pready,
   output logic              pslverr,
   output logic [31:0]       prdata,
   output logic              irq,
   // Triggers and sample timing
   input  wire  logic [1:0]  hw_trig,
   input  wire  logic        sb_hw_trig,
   input  wire  logic        sample_valid,
   input  wire  logic [8:0]  bunch_num,
   // Datapath
   input  wire  logic [11:0] filt_in,
   input  wire  logic [15:0] exc_params,
   input  wire  logic        sat_warn,
   input  wire  logic        err_in,
   output logic [11:0]       fb_out,
   output logic              coef_sel,
   output logic [2:0]        bunch_en,
   // Sample memories
   output logic [1:0]        mem_we,
   output logic [23:0]       mem_addr,
   output logic              sb_we,
   output logic [16:0]       sb_addr,
   output logic [1:0]        status_code
);
   import bat_pkg::*;

   // ************************************************************
   // Register bus
   // ************************************************************
   logic [6:0]    ctrl_reg;                // Control bits
   logic [CW-1:0] hold_reg;                // Hold-off count
   logic [CW-1:0] grow_reg;                // Growth count
   logic [CW-1:0] post_reg;                // Post-trigger count
   logic [3:0]    irq_reg;                 // Sticky events
   logic [3:0]    imask_reg;               // Event mask
   logic [8:0]    midx_reg;                // Selected bunch for mask access
   logic [15:0]   sbexc_reg;               // Latched excitation parameters
   logic [NB-1:0] fbm_reg, drm_reg, acm_reg; // Per-bunch enables
   logic          wr, rd, hit;
   logic [5:0]    cmd;                     // One-cycle command strobes
   logic          midx_ok;                 // Index inside 1..470
   logic [8:0]    mi;                      // Zero-based bunch index
   bat_state_e    state_reg;               // Sequencer state, read back on the bus
   logic          eng_reg;                 // Engine in use
   logic          sb_busy;                 // Single-bunch capture running

   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;                   // Zero wait states
   assign midx_ok = (midx_reg != 9'h000) && (midx_reg <= 9'(NB));
   assign mi = midx_reg - 9'h001;
   assign cmd = (wr && paddr == OFS_CMD) ? pwdata[5:0] : 6'h00;

   // Decode, unmapped offsets answer with an error
   always_comb begin
      hit = 1'b1;
      prdata = 32'h0;
      unique case (paddr)
         OFS_CTRL:  prdata = {25'h0, ctrl_reg};
         OFS_CMD:   prdata = 32'h0;
         OFS_HOLD:  prdata = {8'h0, hold_reg};
         OFS_GROW:  prdata = {8'h0, grow_reg};
         OFS_POST:  prdata = {8'h0, post_reg};
         OFS_STAT:  prdata = {25'h0, sb_busy, coef_sel, status_code,
                             eng_reg, state_reg};
         OFS_IRQ:   prdata = {28'h0, irq_reg};
         OFS_IMASK: prdata = {28'h0, imask_reg};
         OFS_MIDX:  prdata = {23'h0, midx_reg};
         OFS_MDAT:  prdata = midx_ok ? {29'h0, acm_reg[mi], drm_reg[mi],
                                        fbm_reg[mi]} : 32'h0;
         OFS_SBEXC: prdata = {16'h0, sbexc_reg};
         default:   hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RST;
         hold_reg <= '0;
         grow_reg <= '0;
         post_reg <= '0;
         imask_reg <= 4'h0;
         midx_reg <= 9'h000;
      end else if (wr) begin
         unique case (paddr)
            OFS_CTRL:  ctrl_reg <= pwdata[6:0];
            OFS_HOLD:  hold_reg <= pwdata[CW-1:0];
            OFS_GROW:  grow_reg <= pwdata[CW-1:0];
            OFS_POST:  post_reg <= pwdata[CW-1:0];
            OFS_IMASK: imask_reg <= pwdata[3:0];
            OFS_MIDX:  midx_reg <= pwdata[8:0];
            default:   ;
         endcase
      end
   end

   // Mask vectors, written one bunch at a time; bunch 0 or above 470 is ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fbm_reg <= '0;
         drm_reg <= '0;
         acm_reg <= '0;
      end else if (wr && paddr == OFS_MDAT && midx_ok) begin // R12 R14
         fbm_reg[mi] <= pwdata[0];
         drm_reg[mi] <= pwdata[1];
         acm_reg[mi] <= pwdata[2];
      end
   end

   // Per-bunch enables for the bunch now in the pipe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         bunch_en <= 3'b000;
      else if (bunch_num != 9'h000 && bunch_num <= 9'(NB)) begin // R13
         bunch_en <= {acm_reg[bunch_num - 9'h001], drm_reg[bunch_num - 9'h001],
                      fbm_reg[bunch_num - 9'h001]};
      end else
         bunch_en <= 3'b000;
   end

   // ************************************************************
   // Multi-bunch sequencer
   // ************************************************************
   logic          inv_reg;                 // Coefficient select inverted
   logic [CW-1:0] hcnt_reg, gcnt_reg, pcnt_reg;
   logic          trig;                    // Trigger at the armed engine
   logic          gd_en;

   // Source select: software strobe or the engine's own hardware input
   assign trig = (state_reg == S_ARMED) &&
                 (ctrl_reg[CTRL_EXT0 + int'(eng_reg)] ? hw_trig[eng_reg] :
                  cmd[CMD_SWTRIG]);              // R1 R8
   assign gd_en = ctrl_reg[CTRL_GD0 + int'(eng_reg)];

   // State and counters; hold-off and post counts tick once per sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= S_IDLE;
         eng_reg <= 1'b0;
         hcnt_reg <= '0;
         pcnt_reg <= '0;
      end else if (cmd[CMD_ABORT]) begin
         state_reg <= S_IDLE;
      end else begin
         unique case (state_reg)
            S_IDLE: begin
               if (cmd[CMD_ARM0] | cmd[CMD_ARM1]) begin
                  state_reg <= S_ARMED;
                  eng_reg <= ~cmd[CMD_ARM0];
               end
            end
            S_ARMED: begin
               if (trig) begin
                  hcnt_reg <= hold_reg;
                  pcnt_reg <= post_reg;
                  // Zero hold-off: virtual trigger is the real one
                  state_reg <= (hold_reg == '0) ? S_RUN : S_HOLD; // R3 R4
               end
            end
            S_HOLD: begin
               if (sample_valid) begin
                  hcnt_reg <= hcnt_reg - 24'h1;
                  if (hcnt_reg == 24'h1)
                     state_reg <= S_RUN;  // R4
               end
            end
            S_RUN: begin
               // Zero post time stops at the virtual trigger
               if (pcnt_reg == '0)
                  state_reg <= S_IDLE;
               else if (sample_valid) begin
                  pcnt_reg <= pcnt_reg - 24'h1;
                  if (pcnt_reg == 24'h1)
                     state_reg <= S_IDLE; // R7
               end
            end
         endcase
      end
   end

   // Inversion: set at trigger, counted from the virtual trigger.
   // Runs on its own so a growth time longer than the capture still ends.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inv_reg <= 1'b0;
         gcnt_reg <= '0;
      end else if (cmd[CMD_ABORT]) begin
         inv_reg <= 1'b0;
      end else if (trig && gd_en) begin
         inv_reg <= 1'b1;                  // R2
         gcnt_reg <= grow_reg;
      end else if (inv_reg && state_reg != S_HOLD && state_reg != S_ARMED) begin
         if (gcnt_reg == '0)
            inv_reg <= 1'b0;               // R6
         else if (sample_valid) begin
            gcnt_reg <= gcnt_reg - 24'h1;  // R5
            if (gcnt_reg == 24'h1)
               inv_reg <= 1'b0;            // R6
         end
      end
   end
   assign coef_sel = ctrl_reg[CTRL_CSEL] ^ inv_reg; // R2 R6

   // Capture address: circular while armed gives pre-trigger data.
   // Nothing is erased, so a short run leaves older samples behind.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mem_addr <= '0;
      else if (state_reg == S_IDLE && (cmd[CMD_ARM0] | cmd[CMD_ARM1]))
         mem_addr <= '0;
      else if (state_reg != S_IDLE && sample_valid) begin // R16
         if (mem_addr == (eng_reg ? DEPTH1 : DEPTH0) - 24'h1)
            mem_addr <= '0;                // R9
         else
            mem_addr <= mem_addr + 24'h1;
      end
   end
   assign mem_we = (state_reg != S_IDLE && sample_valid) ?
                   (eng_reg ? 2'b10 : 2'b01) : 2'b00; // R8

   // ************************************************************
   // Single-bunch engine
   // ************************************************************
   logic sb_arm_reg;                       // Waiting for trigger
   logic sb_trig;
   assign sb_trig = sb_arm_reg &&
                    (ctrl_reg[CTRL_SBEXT] ? sb_hw_trig : cmd[CMD_SBTRIG]);

   // Post-trigger only: writing begins at the trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_arm_reg <= 1'b0;
         sb_busy <= 1'b0;
         sb_addr <= '0;
         sbexc_reg <= 16'h0;
      end else if (cmd[CMD_ABORT]) begin
         sb_arm_reg <= 1'b0;
         sb_busy <= 1'b0;
      end else if (sb_trig) begin
         sb_arm_reg <= 1'b0;
         sb_busy <= 1'b1;                  // R10
         sb_addr <= '0;
         sbexc_reg <= exc_params;          // R11
      end else if (sb_busy && sample_valid) begin
         sb_addr <= sb_addr + 17'h1;
         if (sb_addr == SB_LEN - 17'h1)
            sb_busy <= 1'b0;               // R10
      end else if (cmd[CMD_SBARM] && !sb_busy)
         sb_arm_reg <= 1'b1;
   end
   assign sb_we = sb_busy & sample_valid;

   // ************************************************************
   // Output gate, status and events
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         fb_out <= 12'h000;
      else
         fb_out <= ctrl_reg[CTRL_FB_ON] ? filt_in : 12'h000; // R15
   end

   // Error outranks the saturation warning
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         status_code <= ST_OK;
      else
         status_code <= err_in ? ST_ERR : (sat_warn ? ST_WARN : ST_OK); // R18
   end

   // Sticky events; a read clears them but a new event in that cycle stays
   logic [3:0] ev;
   logic       mb_end, sb_end;
   assign mb_end = state_reg != S_IDLE && state_reg != S_ARMED &&
                   ((state_reg == S_RUN && pcnt_reg == '0) ||
                    (state_reg == S_RUN && sample_valid && pcnt_reg == 24'h1));
   assign sb_end = sb_busy && sample_valid && sb_addr == SB_LEN - 17'h1;
   assign ev = {err_in, sb_end, mb_end, trig};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_reg <= 4'h0;
      else if (rd && paddr == OFS_IRQ)
         irq_reg <= ev;
      else
         irq_reg <= irq_reg | ev;
   end
   assign irq = |(irq_reg & imask_reg);

   // ************************************************************
   // Checks
   // ************************************************************
   property p_inv;
      @(posedge pclk) disable iff (!presetn)
      trig && gd_en && !cmd[CMD_ABORT] |=> inv_reg && coef_sel != ctrl_reg[CTRL_CSEL];
   endproperty
   a_inv: assert property (p_inv) else $error("no inversion at trigger"); // R2
   property p_h0;
      @(posedge pclk) disable iff (!presetn)
      trig && hold_reg == '0 && !cmd[CMD_ABORT] |=> state_reg == S_RUN;
   endproperty
   a_h0: assert property (p_h0) else $error("zero hold-off not skipped"); // R3
   property p_h1;
      @(posedge pclk) disable iff (!presetn)
      trig && hold_reg != '0 && !cmd[CMD_ABORT] |=> state_reg == S_HOLD;
   endproperty
   a_h1: assert property (p_h1) else $error("hold-off not started"); // R3
   property p_vt;
      @(posedge pclk) disable iff (!presetn)
      state_reg == S_HOLD && sample_valid && hcnt_reg == 24'h1 && !cmd[CMD_ABORT]
      |=> state_reg == S_RUN;
   endproperty
   a_vt: assert property (p_vt) else $error("virtual trigger late"); // R4
   property p_rst;
      @(posedge pclk) disable iff (!presetn)
      $fell(inv_reg) |-> coef_sel == ctrl_reg[CTRL_CSEL] && state_reg != S_HOLD &&
      ($past(cmd[CMD_ABORT]) || $past(gcnt_reg) <= 24'h1);
   endproperty
   a_rst: assert property (p_rst) else $error("select not restored"); // R6
   property p_post;
      @(posedge pclk) disable iff (!presetn)
      state_reg == S_RUN && sample_valid && pcnt_reg == 24'h1 |=> state_reg == S_IDLE;
   endproperty
   a_post: assert property (p_post) else $error("capture did not stop"); // R7
   property p_gate;
      @(posedge pclk) disable iff (!presetn)
      !ctrl_reg[CTRL_FB_ON] |=> fb_out == 12'h000;
   endproperty
   a_gate: assert property (p_gate) else $error("output not gated"); // R15
   property p_exc;
      @(posedge pclk) disable iff (!presetn)
      sb_trig && !cmd[CMD_ABORT] |=> sbexc_reg == $past(exc_params) && sb_busy;
   endproperty
   a_exc: assert property (p_exc) else $error("excitation not latched"); // R11
   property p_st;
      @(posedge pclk) disable iff (!presetn)
      err_in |=> status_code == ST_ERR;
   endproperty
   a_st: assert property (p_st) else $error("error not reported"); // R18
   c_gd: cover property (@(posedge pclk) disable iff (!presetn) $fell(inv_reg));
   c_hold: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == S_HOLD ##1 state_reg == S_RUN);
   c_sb: cover property (@(posedge pclk) disable iff (!presetn) $fell(sb_busy));
endmodule : bat_seq
`default_nettype wire

// >>> design/bat_pkg.sv
// Constants, register map and state codes of the acquisition trigger sequencer.
// Assumes a single APB clock domain; the sequencer and the bench import this package, the far-side model does not.
package bat_pkg;
   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00; // Control bits
   localparam logic [7:0] OFS_CMD    = 8'h04; // Command strobes
   localparam logic [7:0] OFS_HOLD   = 8'h08; // Hold-off count
   localparam logic [7:0] OFS_GROW   = 8'h0c; // Growth count
   localparam logic [7:0] OFS_POST   = 8'h10; // Post-trigger count
   localparam logic [7:0] OFS_STAT   = 8'h14; // Live status
   localparam logic [7:0] OFS_IRQ    = 8'h18; // Sticky events
   localparam logic [7:0] OFS_IMASK  = 8'h1c; // Event mask
   localparam logic [7:0] OFS_MIDX   = 8'h20; // Mask bunch index
   localparam logic [7:0] OFS_MDAT   = 8'h24; // Mask bits of bunch
   localparam logic [7:0] OFS_SBEXC  = 8'h28; // Latched excitation
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_FB_ON   = 0; // Feedback output on
   localparam int CTRL_CSEL    = 1; // Base coefficient set select
   localparam int CTRL_GD0     = 2; // Grow/damp, external memory engine
   localparam int CTRL_GD1     = 3; // Grow/damp, block memory engine
   localparam int CTRL_EXT0    = 4; // External trigger, engine 0
   localparam int CTRL_EXT1    = 5; // External trigger, engine 1
   localparam int CTRL_SBEXT   = 6; // External trigger, single bunch
   localparam int CMD_ARM0     = 0; // Arm engine 0
   localparam int CMD_ARM1     = 1; // Arm engine 1
   localparam int CMD_SWTRIG   = 2; // Software trigger, multi-bunch
   localparam int CMD_SBARM    = 3; // Arm single bunch
   localparam int CMD_SBTRIG   = 4; // Software trigger, single bunch
   localparam int CMD_ABORT    = 5; // Stop everything
   localparam int EV_TRIG      = 0; // Trigger taken
   localparam int EV_DONE      = 1; // Multi-bunch capture ended
   localparam int EV_SBDONE    = 2; // Single-bunch capture ended
   localparam int EV_ERR       = 3; // Error summary seen
   // ************************************************************
   // Sizes and reset values
   // ************************************************************
   localparam int NB    = 470;                 // Bunches, harmonic number
   localparam int CW    = 24;                  // Count width
   localparam logic [23:0] DEPTH0 = 24'hc00000; // 12M samples
   localparam logic [23:0] DEPTH1 = 24'h045000; // 276k samples
   localparam logic [16:0] SB_LEN = 17'h18000;  // 96k samples
   localparam logic [6:0]  CTRL_RST = 7'h00;    // Feedback off after reset
   localparam logic [1:0]  ST_OK = 2'h0;        // Status: no errors
   localparam logic [1:0]  ST_WARN = 2'h1;      // Status: saturation
   localparam logic [1:0]  ST_ERR = 2'h2;       // Status: error
   // Sequencer states
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_ARMED = 2'b01,
      S_HOLD  = 2'b10,
      S_RUN   = 2'b11
   } bat_state_e;
endpackage : bat_pkg

// >>> tb/bat_far.sv
// Far-side model: bunch timing, sample strobes, filter and excitation data.
// Assumes the bench raises run only while it wants samples to flow.
`timescale 1ns/1ps
`default_nettype none
module bat_far (
   // Clock and control from the bench
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   // Datapath toward the sequencer
   output logic             sample_valid,
   output logic [8:0]       bunch_num,
   output logic [11:0]      filt_in,
   output logic [15:0]      exc_params
);
   // Bunch number walks 1..470 every clock, like the ring turning
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bunch_num <= 9'h001;
         filt_in   <= 12'h000;
      end else begin
         bunch_num <= (bunch_num == 9'h1d6) ? 9'h001 : bunch_num + 9'h001;
         // Moves every cycle so a stale copy can never pass as fresh
         filt_in   <= filt_in + 12'h2a7;
      end
   end
   // Strobe every other clock while running; excitation moves only then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_valid <= 1'b0;
         exc_params   <= 16'h5a3c;
      end else begin
         sample_valid <= run & ~sample_valid;
         if (run) begin
            exc_params <= exc_params + 16'h1357;
         end
      end
   end
endmodule : bat_far
`default_nettype wire

// >>> tb/tb_bat_seq.sv
// Self-checking bench for the acquisition trigger sequencer.
// Assumes zero-wait APB answers and the far-side model bat_far.
`timescale 1ns/1ps
`default_nettype none
module tb_bat_seq;
   import bat_pkg::*;
   // Bench-driven inputs
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, sb_hw_trig, sat_warn, err_in, go;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [1:0]  hw_trig, mem_we, status_code;
   // Design and model outputs
   logic        pready, pslverr, irq, sample_valid, coef_sel, sb_we, re;
   logic [8:0]  bunch_num;
   logic [11:0] filt_in, fb_out;
   logic [15:0] exc_params, ev;
   logic [2:0]  bunch_en;
   logic [23:0] mem_addr;
   logic [16:0] sb_addr;
   int          failures = 0;
   int          n_compared = 0;
   int          k, m;

   // 200 MHz clock
   always #2.5 pclk = ~pclk;

   bat_seq dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .irq(irq), .hw_trig(hw_trig), .sb_hw_trig(sb_hw_trig), .sample_valid(sample_valid),
      .bunch_num(bunch_num), .filt_in(filt_in), .exc_params(exc_params), .sat_warn(sat_warn),
      .err_in(err_in), .fb_out(fb_out), .coef_sel(coef_sel), .bunch_en(bunch_en),
      .mem_we(mem_we), .mem_addr(mem_addr), .sb_we(sb_we), .sb_addr(sb_addr),
      .status_code(status_code)
   );
   bat_far far (
      .pclk(pclk), .presetn(presetn), .run(go), .sample_valid(sample_valid),
      .bunch_num(bunch_num), .filt_in(filt_in), .exc_params(exc_params)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task automatic tick;
      @(posedge pclk);
      #1;
   endtask : tick
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // A slave that never answers ends the run
      if (n >= 20) begin
         failures++;
         end_sim();
      end
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rv);
   endtask : rd
   task automatic fb_chk(input logic on);
      logic [11:0] f;
      tick();
      f = filt_in;
      tick();
      chk("fb_out", on ? {20'h0, f} : 32'h0, {20'h0, fb_out});
   endtask : fb_chk
   task automatic ben_chk(input logic [8:0] b, input logic [2:0] exp);
      int n;
      for (n = 0; n < 600 && bunch_num !== b; n++) tick();
      tick();
      chk("bunch_en", {29'h0, exp}, {29'h0, bunch_en});
   endtask : ben_chk
   task automatic stc(input logic s, input logic e, input logic [1:0] exp);
      @(posedge pclk);
      sat_warn <= s;
      err_in <= e;
      repeat (2) tick();
      chk("status_code", {30'h0, exp}, {30'h0, status_code});
   endtask : stc
   // Full multi-bunch sequence; counts samples and tracks select and strobes
   task automatic run_seq(input int eng, ext, gd, cs, hold, grow, post);
      int n;
      go <= 1'b0;
      wr(OFS_CTRL, 32'(1 | (cs << CTRL_CSEL) | (gd << (CTRL_GD0 + eng))
                     | (ext << (CTRL_EXT0 + eng))));
      wr(OFS_HOLD, 32'(hold));
      wr(OFS_GROW, 32'(grow));
      wr(OFS_POST, 32'(post));
      wr(OFS_CMD, 32'(1 << (CMD_ARM0 + eng)));
      if (ext != 0) begin
         @(posedge pclk);
         hw_trig <= 2'(1 << eng);
         @(posedge pclk);
         hw_trig <= 2'b00;
      end else begin
         wr(OFS_CMD, 32'(1 << CMD_SWTRIG));
      end
      rd("state", OFS_STAT, 32'((hold != 0 ? 2 : 3) | (eng << 2) | ((cs ^ gd) << 5)));
      go <= 1'b1;
      n = 0;
      for (k = 0; k < 4000 && n < hold + post; k++) begin
         @(posedge pclk);
         if (sample_valid === 1'b1) n++;
         #1;
         chk("coef_sel", 32'(cs ^ (gd & int'(n < hold + grow))), {31'h0, coef_sel});
         chk("mem_we", (n < hold + post && sample_valid === 1'b1) ? 32'(1 << eng) : 0,
             {30'h0, mem_we});
      end
      if (n < hold + post) begin
         failures++;
         end_sim();
      end
      chk("mem_addr", 32'(hold + post), {8'h0, mem_addr});
      @(posedge pclk);
      go <= 1'b0;
      apb(1'b0, OFS_STAT, 32'h0);
      chk("idle", 32'(cs << 2), {29'h0, rv[5], rv[1:0]});
      chk("irq", 32'h1, {31'h0, irq});
      rd("events", OFS_IRQ, 32'h3);
      tick();
      chk("irq", 32'h0, {31'h0, irq});
      $display("sequence eng %0d hold %0d done", eng, hold);
   endtask : run_seq

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hw_trig = 2'b00;
      sb_hw_trig = 1'b0;
      sat_warn = 1'b0;
      err_in = 1'b0;
      go = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      tick();
      chk("reset outs", 32'h0, {fb_out, irq, coef_sel, mem_we});
      rd("ctrl", OFS_CTRL, {25'h0, CTRL_RST});
      rd("stat", OFS_STAT, 32'h0);
      apb(1'b0, 8'h2c, 32'h0);
      chk("pslverr", 32'h1, {31'h0, re});
      chk("unmapped", 32'h0, rv);
      $display("reset test done");
      // Feedback gate and base select
      wr(OFS_CTRL, 32'h3);
      fb_chk(1'b1);
      chk("coef_sel", 32'h1, {31'h0, coef_sel});
      wr(OFS_CTRL, 32'h0);
      fb_chk(1'b0);
      $display("feedback gate test done");
      // Mask vectors, ends of the bunch range
      wr(OFS_MIDX, 32'd5);
      wr(OFS_MDAT, 32'h5);
      wr(OFS_MIDX, 32'd470);
      wr(OFS_MDAT, 32'h2);
      rd("mask 470", OFS_MDAT, 32'h2);
      wr(OFS_MIDX, 32'd5);
      rd("mask 5", OFS_MDAT, 32'h5);
      wr(OFS_MIDX, 32'd0);
      rd("mask 0", OFS_MDAT, 32'h0);
      ben_chk(9'd5, 3'b101);
      ben_chk(9'd470, 3'b010);
      ben_chk(9'd6, 3'b000);
      $display("mask test done");
      wr(OFS_IMASK, 32'(1 << EV_DONE | 1 << EV_ERR));
      run_seq(0, 1, 1, 0, 0, 4, 6);
      @(posedge pclk);
      hw_trig <= 2'b01;
      @(posedge pclk);
      hw_trig <= 2'b00;
      apb(1'b0, OFS_STAT, 32'h0);
      chk("unarmed trigger", 32'h0, {30'h0, rv[1:0]});
      run_seq(1, 0, 1, 1, 3, 2, 5);
      run_seq(0, 0, 0, 0, 0, 3, 4);
      run_seq(1, 1, 0, 1, 2, 1, 3);
      // Single-bunch capture with hardware trigger
      wr(OFS_CTRL, 32'(1 << CTRL_SBEXT));
      wr(OFS_CMD, 32'(1 << CMD_SBARM));
      ev = exc_params;
      @(posedge pclk);
      sb_hw_trig <= 1'b1;
      @(posedge pclk);
      sb_hw_trig <= 1'b0;
      go <= 1'b1;
      m = 0;
      for (k = 0; k < 40; k++) begin
         tick();
         chk("sb_we", {31'h0, sample_valid}, {31'h0, sb_we});
         chk("sb_addr", 32'(m), {15'h0, sb_addr});
         if (sample_valid === 1'b1) m++;
      end
      rd("excitation", OFS_SBEXC, {16'h0, ev});
      wr(OFS_CMD, 32'(1 << CMD_ABORT));
      apb(1'b0, OFS_STAT, 32'h0);
      chk("sb busy", 32'h0, {31'h0, rv[6]});
      $display("single bunch test done");
      // Status summary and error event
      stc(1'b1, 1'b0, ST_WARN);
      stc(1'b1, 1'b1, ST_ERR);
      chk("irq err", 32'h1, {31'h0, irq});
      stc(1'b0, 1'b0, ST_OK);
      rd("events", OFS_IRQ, 32'(1 << EV_ERR));
      tick();
      chk("irq", 32'h0, {31'h0, irq});
      $display("status test done");
      end_sim();
   end
endmodule : tb_bat_seq
`default_nettype wire
